// ===== hdl/pif_enable_reg.sv
`timescale 1ns/1ns
module pif_enable_reg #(
    parameter logic [7:0] IMPL_MASK = 8'hFF
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic wr_en_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] value_out
);
    import pif_pkg::*;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            value_out <= RESET_VALUE;
        end else if (wr_en_in) begin
            value_out <= wdata_in & IMPL_MASK; // RULE_09
        end
    end
endmodule

// ===== hdl/pif_flag_bank.sv
`timescale 1ns/1ns
module pif_flag_bank #(
    parameter logic [7:0] IMPL_MASK = 8'hFF
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [7:0] set_in,
    input wire logic wr_en_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] flags_out
);
    import pif_pkg::*;
    logic [7:0] flags_d;

    // A write stores its implemented bits, but an event in the same cycle still wins.
    always_comb begin
        flags_d = flags_out;
        if (wr_en_in) begin
            flags_d = wdata_in;
        end
        flags_d = (flags_d | set_in) & IMPL_MASK; // RULE_01 RULE_04
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            flags_out <= RESET_VALUE; // RULE_05
        end else begin
            flags_out <= flags_d;
        end
    end
endmodule

// ===== hdl/pif_top.sv
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ns
//
// Contract
// RULE_01: Flags set on their event regardless of per-source or global enables.
// RULE_02: Software should clear flags before enabling the matching source.
// RULE_03: An implemented flag reads one while pending, zero otherwise.
// RULE_04: Unimplemented bits ignore writes and read zero.
// RULE_05: Implemented flags are read/write and reset to zero on every reset.
// RULE_06: Second register: osc fail, comparators, nvm, serial1 collision, lcd, capcomp two.
// RULE_07: Third register: capcomp five, four, three, timer six at 3, timer four at 1.
// RULE_08: Fourth register: uart2 rx 5, tx 4, serial2 collision 1, serial2 event 0.
// RULE_09: Each flag has an enable at the same position; global 7, peripheral 6.
// RULE_10: Interrupt requested when flag and enable, peripheral and global enables set.
module pif_top (
    input wire logic SYS_CLK_IN,
    input wire logic SRST_IN,
    input wire logic [pif_pkg::REG_AW-1:0] ADDR_IN,
    input wire logic [pif_pkg::DATA_W-1:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [pif_pkg::DATA_W-1:0] RDATA_OUT,
    input wire logic [7:0] BANK1_EVENTS_IN,
    input wire logic OSC_FAIL_IN,
    input wire logic COMPARATOR_TWO_IN,
    input wire logic COMPARATOR_ONE_IN,
    input wire logic NVM_WRITE_DONE_IN,
    input wire logic SERIAL1_COLLISION_IN,
    input wire logic LCD_EVENT_IN,
    input wire logic CAPCOMP_TWO_IN,
    input wire logic CAPCOMP_FIVE_IN,
    input wire logic CAPCOMP_FOUR_IN,
    input wire logic CAPCOMP_THREE_IN,
    input wire logic TIMER_SIX_MATCH_IN,
    input wire logic TIMER_FOUR_MATCH_IN,
    input wire logic UART2_RX_IN,
    input wire logic UART2_TX_IN,
    input wire logic SERIAL2_COLLISION_IN,
    input wire logic SERIAL2_EVENT_IN,
    output logic IRQ_OUT
);
    import pif_pkg::*;

    localparam logic [7:0] BANK_MASKS [NUM_BANKS] = '{MASK_BANK_1, MASK_BANK_2,
                                                      MASK_BANK_3, MASK_BANK_4};

    logic [7:0] set_vec [NUM_BANKS];
    logic [7:0] flags [NUM_BANKS];
    logic [7:0] enables [NUM_BANKS];
    logic [7:0] control_q;
    logic [7:0] rdata_d;
    logic irq_d;
    logic [NUM_BANKS-1:0] bank_pending;

    // Event inputs come from peripherals on the same clock, so no synchroniser.
    always_comb begin
        set_vec[0] = BANK1_EVENTS_IN;
        set_vec[1] = 8'h00;
        set_vec[1][OSC_FAIL_BIT] = OSC_FAIL_IN; // RULE_06
        set_vec[1][COMPARATOR_TWO_BIT] = COMPARATOR_TWO_IN; // RULE_06
        set_vec[1][COMPARATOR_ONE_BIT] = COMPARATOR_ONE_IN; // RULE_06
        set_vec[1][NVM_WRITE_DONE_BIT] = NVM_WRITE_DONE_IN; // RULE_06
        set_vec[1][SERIAL1_COLLISION_BIT] = SERIAL1_COLLISION_IN; // RULE_06
        set_vec[1][LCD_EVENT_BIT] = LCD_EVENT_IN; // RULE_06
        set_vec[1][CAPCOMP_TWO_BIT] = CAPCOMP_TWO_IN; // RULE_06
        set_vec[2] = 8'h00;
        set_vec[2][CAPCOMP_FIVE_BIT] = CAPCOMP_FIVE_IN; // RULE_07
        set_vec[2][CAPCOMP_FOUR_BIT] = CAPCOMP_FOUR_IN; // RULE_07
        set_vec[2][CAPCOMP_THREE_BIT] = CAPCOMP_THREE_IN; // RULE_07
        set_vec[2][TIMER_SIX_MATCH_BIT] = TIMER_SIX_MATCH_IN; // RULE_07
        set_vec[2][TIMER_FOUR_MATCH_BIT] = TIMER_FOUR_MATCH_IN; // RULE_07
        set_vec[3] = 8'h00;
        set_vec[3][UART2_RX_BIT] = UART2_RX_IN; // RULE_08
        set_vec[3][UART2_TX_BIT] = UART2_TX_IN; // RULE_08
        set_vec[3][SERIAL2_COLLISION_BIT] = SERIAL2_COLLISION_IN; // RULE_08
        set_vec[3][SERIAL2_EVENT_BIT] = SERIAL2_EVENT_IN; // RULE_08
    end

    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        pif_flag_bank #(
            .IMPL_MASK(BANK_MASKS[b])
        ) u_flags (
            .clk_in(SYS_CLK_IN),
            .srst_in(SRST_IN),
            .set_in(set_vec[b]),
            .wr_en_in(WR_IN && (ADDR_IN == ADDR_FLAGS_1 + 4'(b))),
            .wdata_in(WDATA_IN),
            .flags_out(flags[b])
        );
        pif_enable_reg #(
            .IMPL_MASK(BANK_MASKS[b])
        ) u_enable (
            .clk_in(SYS_CLK_IN),
            .srst_in(SRST_IN),
            .wr_en_in(WR_IN && (ADDR_IN == ADDR_ENABLE_1 + 4'(b))),
            .wdata_in(WDATA_IN),
            .value_out(enables[b])
        );
        assign bank_pending[b] = |(flags[b] & enables[b]);
    end

    // Only the two enable bits of the control register live here.
    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            control_q <= RESET_VALUE;
        end else if (WR_IN && ADDR_IN == ADDR_CONTROL) begin
            control_q <= WDATA_IN & CONTROL_MASK; // RULE_09
        end
    end

    always_comb begin
        unique case (ADDR_IN)
            ADDR_CONTROL: rdata_d = control_q;
            ADDR_ENABLE_1: rdata_d = enables[0];
            ADDR_ENABLE_2: rdata_d = enables[1];
            ADDR_ENABLE_3: rdata_d = enables[2];
            ADDR_ENABLE_4: rdata_d = enables[3];
            ADDR_FLAGS_1: rdata_d = flags[0]; // RULE_03
            ADDR_FLAGS_2: rdata_d = flags[1]; // RULE_03
            ADDR_FLAGS_3: rdata_d = flags[2]; // RULE_03
            ADDR_FLAGS_4: rdata_d = flags[3]; // RULE_03
            default: rdata_d = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe, zero otherwise.
    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            RDATA_OUT <= 8'h00;
        end else if (RD_IN) begin
            RDATA_OUT <= rdata_d;
        end else begin
            RDATA_OUT <= 8'h00;
        end
    end

    // Registered request: a pending source that software has not cleared first fires at once.
    assign irq_d = (|bank_pending) && control_q[PERIPH_EN_BIT] && control_q[GLOBAL_EN_BIT]; // RULE_10 RULE_02

    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            IRQ_OUT <= 1'b0;
        end else begin
            IRQ_OUT <= irq_d; // RULE_10
        end
    end

    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (SRST_IN);

    sequence clear_write_s;
        WR_IN && ADDR_IN == ADDR_FLAGS_2 && WDATA_IN == 8'h00;
    endsequence

    sequence irq_armed_s;
        control_q[GLOBAL_EN_BIT] && control_q[PERIPH_EN_BIT];
    endsequence

    set_wins_clear_a: assert property (clear_write_s ##0 OSC_FAIL_IN |=> flags[1][OSC_FAIL_BIT]) // RULE_01
        else $error("event lost against a clear");
    event_sets_flag_a: assert property (UART2_RX_IN |=> flags[3][UART2_RX_BIT]) // RULE_01
        else $error("event did not set its flag");
    flag_read_a: assert property (RD_IN && ADDR_IN == ADDR_FLAGS_3 |=> RDATA_OUT == $past(flags[2])) // RULE_03
        else $error("flag read mismatch");
    unimpl_zero_a: assert property ((flags[1][1] == 1'b0) && (flags[2] & 8'h85) == 8'h00) // RULE_04
        else $error("unimplemented flag bit set");
    unimpl4_zero_a: assert property ((flags[3] & 8'hCC) == 8'h00) // RULE_04
        else $error("unimplemented bit in fourth register set");
    reset_clears_a: assert property (disable iff (1'b0) SRST_IN |=> flags[1] == 8'h00 && !IRQ_OUT) // RULE_05
        else $error("reset did not clear");
    sw_write_a: assert property (WR_IN && ADDR_IN == ADDR_FLAGS_4 && !SERIAL2_EVENT_IN
        |=> flags[3][SERIAL2_EVENT_BIT] == $past(WDATA_IN[SERIAL2_EVENT_BIT])) // RULE_05
        else $error("flag write not stored");
    timer_pos_a: assert property (TIMER_FOUR_MATCH_IN |=> flags[2][TIMER_FOUR_MATCH_BIT]) // RULE_07
        else $error("timer four flag misplaced");
    ctl_mask_a: assert property ((control_q & 8'h3F) == 8'h00) // RULE_09
        else $error("control register holds unexpected bits");
    irq_gate_a: assert property (!control_q[GLOBAL_EN_BIT] ##1 !control_q[GLOBAL_EN_BIT] |-> !IRQ_OUT) // RULE_10
        else $error("interrupt with global enable clear");
    irq_raise_a: assert property (irq_armed_s ##0 (|(flags[2] & enables[2])) |=> IRQ_OUT) // RULE_10
        else $error("interrupt not raised");

    // Every named source sets its own flag at the next edge, whatever the enables hold.
    bank1_set_a: assert property (BANK1_EVENTS_IN != 8'h00 // RULE_01
        |=> (flags[0] & $past(BANK1_EVENTS_IN)) == $past(BANK1_EVENTS_IN))
        else $error("first register event lost");
    osc_fail_set_a: assert property (OSC_FAIL_IN // RULE_06
        |=> flags[1][OSC_FAIL_BIT]) else $error("oscillator fail flag not set");
    cmp_two_set_a: assert property (COMPARATOR_TWO_IN // RULE_06
        |=> flags[1][COMPARATOR_TWO_BIT]) else $error("comparator two flag not set");
    cmp_one_set_a: assert property (COMPARATOR_ONE_IN // RULE_06
        |=> flags[1][COMPARATOR_ONE_BIT]) else $error("comparator one flag not set");
    nvm_done_set_a: assert property (NVM_WRITE_DONE_IN // RULE_06
        |=> flags[1][NVM_WRITE_DONE_BIT]) else $error("nvm write flag not set");
    ser1_coll_set_a: assert property (SERIAL1_COLLISION_IN // RULE_06
        |=> flags[1][SERIAL1_COLLISION_BIT]) else $error("serial1 collision flag not set");
    lcd_event_set_a: assert property (LCD_EVENT_IN // RULE_06
        |=> flags[1][LCD_EVENT_BIT]) else $error("lcd flag not set");
    capcomp_two_set_a: assert property (CAPCOMP_TWO_IN // RULE_06
        |=> flags[1][CAPCOMP_TWO_BIT]) else $error("capcomp two flag not set");
    capcomp_five_set_a: assert property (CAPCOMP_FIVE_IN // RULE_07
        |=> flags[2][CAPCOMP_FIVE_BIT]) else $error("capcomp five flag not set");
    capcomp_four_set_a: assert property (CAPCOMP_FOUR_IN // RULE_07
        |=> flags[2][CAPCOMP_FOUR_BIT]) else $error("capcomp four flag not set");
    capcomp_three_set_a: assert property (CAPCOMP_THREE_IN // RULE_07
        |=> flags[2][CAPCOMP_THREE_BIT]) else $error("capcomp three flag not set");
    timer_six_set_a: assert property (TIMER_SIX_MATCH_IN // RULE_07
        |=> flags[2][TIMER_SIX_MATCH_BIT]) else $error("timer six flag not set");
    uart2_tx_set_a: assert property (UART2_TX_IN // RULE_08
        |=> flags[3][UART2_TX_BIT]) else $error("uart2 transmit flag not set");
    ser2_coll_set_a: assert property (SERIAL2_COLLISION_IN // RULE_08
        |=> flags[3][SERIAL2_COLLISION_BIT]) else $error("serial2 collision flag not set");
    ser2_event_set_a: assert property (SERIAL2_EVENT_IN // RULE_08
        |=> flags[3][SERIAL2_EVENT_BIT]) else $error("serial2 event flag not set");

    // A software write never drops an event that lands in the same cycle.
    bank1_keep_a: assert property (WR_IN && ADDR_IN == ADDR_FLAGS_1 // RULE_01
        |=> (flags[0] & $past(set_vec[0])) == $past(set_vec[0]))
        else $error("event lost on write");
    bank2_keep_a: assert property (WR_IN && ADDR_IN == ADDR_FLAGS_2 // RULE_01
        |=> (flags[1] & $past(set_vec[1])) == $past(set_vec[1]))
        else $error("event lost on write");
    bank3_keep_a: assert property (WR_IN && ADDR_IN == ADDR_FLAGS_3 // RULE_01
        |=> (flags[2] & $past(set_vec[2])) == $past(set_vec[2]))
        else $error("event lost on write");
    bank4_keep_a: assert property (WR_IN && ADDR_IN == ADDR_FLAGS_4 // RULE_01
        |=> (flags[3] & $past(set_vec[3])) == $past(set_vec[3]))
        else $error("event lost on write");

    // Each read returns the register as it stood on the strobe edge.
    ctl_read_a: assert property (RD_IN && ADDR_IN == ADDR_CONTROL // RULE_09
        |=> RDATA_OUT == $past(control_q)) else $error("control read mismatch");
    en1_read_a: assert property (RD_IN && ADDR_IN == ADDR_ENABLE_1 // RULE_09
        |=> RDATA_OUT == $past(enables[0])) else $error("enable read mismatch");
    en2_read_a: assert property (RD_IN && ADDR_IN == ADDR_ENABLE_2 // RULE_09
        |=> RDATA_OUT == $past(enables[1])) else $error("enable read mismatch");
    en3_read_a: assert property (RD_IN && ADDR_IN == ADDR_ENABLE_3 // RULE_09
        |=> RDATA_OUT == $past(enables[2])) else $error("enable read mismatch");
    en4_read_a: assert property (RD_IN && ADDR_IN == ADDR_ENABLE_4 // RULE_09
        |=> RDATA_OUT == $past(enables[3])) else $error("enable read mismatch");
    flags1_read_a: assert property (RD_IN && ADDR_IN == ADDR_FLAGS_1 // RULE_03
        |=> RDATA_OUT == $past(flags[0])) else $error("flag read mismatch");
    flags2_read_a: assert property (RD_IN && ADDR_IN == ADDR_FLAGS_2 // RULE_03
        |=> RDATA_OUT == $past(flags[1])) else $error("flag read mismatch");
    flags4_read_a: assert property (RD_IN && ADDR_IN == ADDR_FLAGS_4 // RULE_03
        |=> RDATA_OUT == $past(flags[3])) else $error("flag read mismatch");

    // With no event in flight a write stores exactly the implemented bits.
    ctl_write_a: assert property (WR_IN && ADDR_IN == ADDR_CONTROL // RULE_09
        |=> control_q == ($past(WDATA_IN) & CONTROL_MASK)) else $error("control write lost");
    en1_write_a: assert property (WR_IN && ADDR_IN == ADDR_ENABLE_1 // RULE_09
        |=> enables[0] == ($past(WDATA_IN) & MASK_BANK_1)) else $error("enable write lost");
    en2_write_a: assert property (WR_IN && ADDR_IN == ADDR_ENABLE_2 // RULE_09
        |=> enables[1] == ($past(WDATA_IN) & MASK_BANK_2)) else $error("enable write lost");
    en3_write_a: assert property (WR_IN && ADDR_IN == ADDR_ENABLE_3 // RULE_09
        |=> enables[2] == ($past(WDATA_IN) & MASK_BANK_3)) else $error("enable write lost");
    en4_write_a: assert property (WR_IN && ADDR_IN == ADDR_ENABLE_4 // RULE_09
        |=> enables[3] == ($past(WDATA_IN) & MASK_BANK_4)) else $error("enable write lost");
    flags1_write_a: assert property (WR_IN && ADDR_IN == ADDR_FLAGS_1 && set_vec[0] == 8'h00 // RULE_05
        |=> flags[0] == ($past(WDATA_IN) & MASK_BANK_1)) else $error("flag write lost");
    flags2_write_a: assert property (WR_IN && ADDR_IN == ADDR_FLAGS_2 && set_vec[1] == 8'h00 // RULE_05
        |=> flags[1] == ($past(WDATA_IN) & MASK_BANK_2)) else $error("flag write lost");
    flags3_write_a: assert property (WR_IN && ADDR_IN == ADDR_FLAGS_3 && set_vec[2] == 8'h00 // RULE_05
        |=> flags[2] == ($past(WDATA_IN) & MASK_BANK_3)) else $error("flag write lost");
    flags4_write_a: assert property (WR_IN && ADDR_IN == ADDR_FLAGS_4 && set_vec[3] == 8'h00 // RULE_05
        |=> flags[3] == ($past(WDATA_IN) & MASK_BANK_4)) else $error("flag write lost");

    // Nothing but a write or an event may move a register.
    ctl_hold_a: assert property (!(WR_IN && ADDR_IN == ADDR_CONTROL) // RULE_09
        |=> $stable(control_q)) else $error("control register moved");
    en1_hold_a: assert property (!(WR_IN && ADDR_IN == ADDR_ENABLE_1) // RULE_09
        |=> $stable(enables[0])) else $error("enable register moved");
    en2_hold_a: assert property (!(WR_IN && ADDR_IN == ADDR_ENABLE_2) // RULE_09
        |=> $stable(enables[1])) else $error("enable register moved");
    en3_hold_a: assert property (!(WR_IN && ADDR_IN == ADDR_ENABLE_3) // RULE_09
        |=> $stable(enables[2])) else $error("enable register moved");
    en4_hold_a: assert property (!(WR_IN && ADDR_IN == ADDR_ENABLE_4) // RULE_09
        |=> $stable(enables[3])) else $error("enable register moved");
    flags1_hold_a: assert property (!(WR_IN && ADDR_IN == ADDR_FLAGS_1) && set_vec[0] == 8'h00 // RULE_03
        |=> $stable(flags[0])) else $error("flag moved on its own");
    flags2_hold_a: assert property (!(WR_IN && ADDR_IN == ADDR_FLAGS_2) && set_vec[1] == 8'h00 // RULE_03
        |=> $stable(flags[1])) else $error("flag moved on its own");
    flags3_hold_a: assert property (!(WR_IN && ADDR_IN == ADDR_FLAGS_3) && set_vec[2] == 8'h00 // RULE_03
        |=> $stable(flags[2])) else $error("flag moved on its own");
    flags4_hold_a: assert property (!(WR_IN && ADDR_IN == ADDR_FLAGS_4) && set_vec[3] == 8'h00 // RULE_03
        |=> $stable(flags[3])) else $error("flag moved on its own");

    // Read data stands for one cycle only; unmapped indices and spare bits read zero.
    rdata_idle_a: assert property (!RD_IN |=> RDATA_OUT == 8'h00) // RULE_03
        else $error("read data outside a read");
    unmapped_read_a: assert property (RD_IN && ADDR_IN > ADDR_FLAGS_4 // RULE_04
        |=> RDATA_OUT == 8'h00) else $error("unmapped index read nonzero");
    en_spare_a: assert property ((enables[1] & ~MASK_BANK_2) == 8'h00 // RULE_09
        && (enables[2] & ~MASK_BANK_3) == 8'h00 && (enables[3] & ~MASK_BANK_4) == 8'h00)
        else $error("enable register holds a spare bit");
    periph_gate_a: assert property (!control_q[PERIPH_EN_BIT] |=> !IRQ_OUT) // RULE_10
        else $error("interrupt with peripheral enable clear");
    idle_irq_a: assert property (!(|bank_pending) |=> !IRQ_OUT) // RULE_10
        else $error("interrupt with nothing pending");

    // Every register and the read port come out of reset cleared.
    reset_flags_a: assert property (disable iff (1'b0) SRST_IN // RULE_05
        |=> flags[0] == 8'h00 && flags[2] == 8'h00 && flags[3] == 8'h00)
        else $error("reset left a flag set");
    reset_regs_a: assert property (disable iff (1'b0) SRST_IN // RULE_05
        |=> control_q == 8'h00 && enables[0] == 8'h00 && enables[1] == 8'h00
        && enables[2] == 8'h00 && enables[3] == 8'h00 && RDATA_OUT == 8'h00)
        else $error("reset left a register set");
endmodule

// ===== shared/pif_pkg.sv
package pif_pkg;
    localparam int REG_AW = 4;
    localparam int DATA_W = 8;
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_ENABLE_1 = 4'h1;
    localparam logic [3:0] ADDR_ENABLE_2 = 4'h2;
    localparam logic [3:0] ADDR_ENABLE_3 = 4'h3;
    localparam logic [3:0] ADDR_ENABLE_4 = 4'h4;
    localparam logic [3:0] ADDR_FLAGS_1 = 4'h5;
    localparam logic [3:0] ADDR_FLAGS_2 = 4'h6;
    localparam logic [3:0] ADDR_FLAGS_3 = 4'h7;
    localparam logic [3:0] ADDR_FLAGS_4 = 4'h8;
    localparam int NUM_BANKS = 4;
    localparam logic [7:0] MASK_BANK_1 = 8'hFF;
    localparam logic [7:0] MASK_BANK_2 = 8'hFD;
    localparam logic [7:0] MASK_BANK_3 = 8'h7A;
    localparam logic [7:0] MASK_BANK_4 = 8'h33;
    localparam logic [7:0] CONTROL_MASK = 8'hC0;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    localparam int GLOBAL_EN_BIT = 7;
    localparam int PERIPH_EN_BIT = 6;
    // Bit positions inside the second to fourth flag registers.
    localparam int OSC_FAIL_BIT = 7;
    localparam int COMPARATOR_TWO_BIT = 6;
    localparam int COMPARATOR_ONE_BIT = 5;
    localparam int NVM_WRITE_DONE_BIT = 4;
    localparam int SERIAL1_COLLISION_BIT = 3;
    localparam int LCD_EVENT_BIT = 2;
    localparam int CAPCOMP_TWO_BIT = 0;
    localparam int CAPCOMP_FIVE_BIT = 6;
    localparam int CAPCOMP_FOUR_BIT = 5;
    localparam int CAPCOMP_THREE_BIT = 4;
    localparam int TIMER_SIX_MATCH_BIT = 3;
    localparam int TIMER_FOUR_MATCH_BIT = 1;
    localparam int UART2_RX_BIT = 5;
    localparam int UART2_TX_BIT = 4;
    localparam int SERIAL2_COLLISION_BIT = 1;
    localparam int SERIAL2_EVENT_BIT = 0;
endpackage

// ===== sim/pif_event_src.sv
`timescale 1ns/1ns
module pif_event_src (
    input wire logic clk_in,
    input wire logic fire_in,
    input wire logic [1:0] bank_in,
    input wire logic [2:0] bit_in,
    output logic [7:0] ev1_out,
    output logic [7:0] ev2_out,
    output logic [7:0] ev3_out,
    output logic [7:0] ev4_out
);
    logic [7:0] ev_q [4];
    // A peripheral raises its condition for exactly one clock, so a stuck level cannot mask a lost set.
    always_ff @(posedge clk_in) begin
        ev_q <= '{default: 8'h00};
        if (fire_in) begin
            ev_q[bank_in][bit_in] <= 1'b1;
        end
    end
    assign ev1_out = ev_q[0];
    assign ev2_out = ev_q[1];
    assign ev3_out = ev_q[2];
    assign ev4_out = ev_q[3];
endmodule

// ===== sim/pif_top_test.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module pif_top_test;
    import pif_pkg::*;
    logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, fire = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wd = 8'h00;
    logic [7:0] rdata, ev1, ev2, ev3, ev4, d;
    logic irq;
    logic [1:0] bank = 2'h0;
    logic [2:0] bpos = 3'h0;
    int n_mismatch = 0;
    int checks_done = 0;
    always #20 clk = ~clk;
    pif_event_src src (.clk_in(clk), .fire_in(fire), .bank_in(bank), .bit_in(bpos),
        .ev1_out(ev1), .ev2_out(ev2), .ev3_out(ev3), .ev4_out(ev4));
    pif_top uut (.SYS_CLK_IN(clk), .SRST_IN(srst), .ADDR_IN(addr), .WDATA_IN(wd), .WR_IN(wr),
        .RD_IN(rd), .RDATA_OUT(rdata), .BANK1_EVENTS_IN(ev1), .OSC_FAIL_IN(ev2[7]),
        .COMPARATOR_TWO_IN(ev2[6]), .COMPARATOR_ONE_IN(ev2[5]), .NVM_WRITE_DONE_IN(ev2[4]),
        .SERIAL1_COLLISION_IN(ev2[3]), .LCD_EVENT_IN(ev2[2]), .CAPCOMP_TWO_IN(ev2[0]),
        .CAPCOMP_FIVE_IN(ev3[6]), .CAPCOMP_FOUR_IN(ev3[5]), .CAPCOMP_THREE_IN(ev3[4]),
        .TIMER_SIX_MATCH_IN(ev3[3]), .TIMER_FOUR_MATCH_IN(ev3[1]), .UART2_RX_IN(ev4[5]),
        .UART2_TX_IN(ev4[4]), .SERIAL2_COLLISION_IN(ev4[1]), .SERIAL2_EVENT_IN(ev4[0]),
        .IRQ_OUT(irq));
    function automatic logic [7:0] mask_of(input logic [3:0] a);
        case (a)
            4'h0: return CONTROL_MASK;
            4'h1, 4'h5: return MASK_BANK_1;
            4'h2, 4'h6: return MASK_BANK_2;
            4'h3, 4'h7: return MASK_BANK_3;
            4'h4, 4'h8: return MASK_BANK_4;
            default: return 8'h00;
        endcase
    endfunction
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wd <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic fire_ev(input logic [1:0] b, input logic [2:0] p);
        @(posedge clk);
        fire <= 1'b1;
        bank <= b;
        bpos <= p;
        @(posedge clk);
        fire <= 1'b0;
        @(posedge clk);
    endtask
    // The interrupt output lags a register write by one registered stage.
    task automatic chk_irq(input logic ex);
        repeat (2) @(posedge clk);
        #1 `CHK("irq", ex, irq)
    endtask
    task automatic give_verdict();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic test_reset_values();
        for (int a = 0; a < 10; a++) begin
            rd_reg(4'(a), d);
            `CHK("reset value", 8'h00, d)
        end
    endtask
    task automatic test_rw_masks();
        for (int a = 0; a < 9; a++) begin
            wr_reg(4'(a), 8'hFF);
            rd_reg(4'(a), d);
            `CHK("write ones", mask_of(4'(a)), d)
            wr_reg(4'(a), 8'h00);
            rd_reg(4'(a), d);
            `CHK("write zeros", 8'h00, d)
        end
        wr_reg(4'hF, 8'hFF);
        rd_reg(4'hF, d);
        `CHK("unmapped", 8'h00, d)
    endtask
    task automatic test_events();
        logic [7:0] m;
        wr_reg(ADDR_CONTROL, 8'h00);
        for (int b = 0; b < NUM_BANKS; b++) begin
            m = mask_of(4'(5 + b));
            for (int p = 0; p < 8; p++) begin
                if (m[p]) begin
                    fire_ev(2'(b), 3'(p));
                    rd_reg(4'(5 + b), d);
                    `CHK("event flag", 8'h01 << p, d)
                    wr_reg(4'(5 + b), 8'h00);
                end
            end
        end
    endtask
    // The event reaches the block on the very edge that takes a clearing write.
    task automatic test_set_wins();
        @(posedge clk);
        fire <= 1'b1;
        bank <= 2'h1;
        bpos <= 3'(OSC_FAIL_BIT);
        @(posedge clk);
        fire <= 1'b0;
        wr <= 1'b1;
        addr <= ADDR_FLAGS_2;
        wd <= 8'h00;
        @(posedge clk);
        wr <= 1'b0;
        rd_reg(ADDR_FLAGS_2, d);
        `CHK("set wins", 8'h01 << OSC_FAIL_BIT, d)
        wr_reg(ADDR_FLAGS_2, 8'h00);
    endtask
    task automatic test_irq();
        wr_reg(ADDR_FLAGS_3, 8'h00);
        fire_ev(2'h2, 3'(TIMER_SIX_MATCH_BIT));
        chk_irq(1'b0);
        wr_reg(ADDR_ENABLE_3, 8'h08);
        wr_reg(ADDR_CONTROL, 8'h40);
        chk_irq(1'b0);
        wr_reg(ADDR_CONTROL, 8'hC0);
        chk_irq(1'b1);
        wr_reg(ADDR_ENABLE_3, 8'h02);
        chk_irq(1'b0);
        wr_reg(ADDR_ENABLE_3, 8'h08);
        chk_irq(1'b1);
        wr_reg(ADDR_FLAGS_3, 8'h00);
        chk_irq(1'b0);
    endtask
    task automatic test_mid_reset();
        fire_ev(2'h3, 3'(UART2_RX_BIT));
        wr_reg(ADDR_ENABLE_4, 8'h20);
        chk_irq(1'b1);
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        #1 `CHK("irq after reset", 1'b0, irq)
        test_reset_values();
    endtask
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        test_reset_values();
        test_rw_masks();
        test_events();
        test_set_wins();
        test_irq();
        test_mid_reset();
        give_verdict();
    end
    initial begin
        #400000;
        n_mismatch++;
        give_verdict();
    end
endmodule
